/* File: src/mct_timer.sv */
// Match/capture counter-timer with Wishbone register slave
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`include "mct_timer_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mct_timer
    import mct_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [`MCT_ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    output logic      [31:0]           o_wb_dat,
    output logic                       o_wb_ack,
    input  wire logic [1:0]            i_cap,
    output logic      [3:0]            o_match,
    output logic                       o_irq
);
    // ==========================================================
    // Registers
    logic [7:0]      ctrl;
    logic [W-1:0]    count;
    logic [W-1:0]    pre;
    logic [W-1:0]    plim;
    logic [7:0]      mctl;
    logic [7:0]      emr_act;
    logic [3:0]      cctl;
    logic [W-1:0]    match [4];
    logic [W-1:0]    cap   [2];
    logic [`MCT_IRQ_W-1:0] stat;
    logic [`MCT_IRQ_W-1:0] ien;
    logic [1:0]      cap_q;
    logic [3:0]      hit_q;
    logic [3:0]      hit;

    // ==========================================================
    // Bus decode
    logic        wr;
    logic        rd_ok;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic [31:0] next_rdat;
    assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
    assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                    {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    // Byte-lane merge of write data over the addressed register
    assign wdat = mrg(next_rdat);

    function automatic logic [31:0] mrg(input logic [31:0] old);
        mrg = (old & ~wmask) | (i_wb_dat & wmask);
    endfunction

    always_comb begin
        next_rdat = 32'h0;
        rd_ok = 1'b1;
        case (i_wb_adr)
            `MCT_OFF_CTRL:  next_rdat = 32'(ctrl);
            `MCT_OFF_COUNT: next_rdat = 32'(count);
            `MCT_OFF_PRE:   next_rdat = 32'(pre);
            `MCT_OFF_PLIM:  next_rdat = 32'(plim);
            `MCT_OFF_MCTL:  next_rdat = 32'(mctl);
            `MCT_OFF_EMR:   next_rdat = {20'h0, emr_act, o_match};
            `MCT_OFF_CCTL:  next_rdat = 32'(cctl);
            `MCT_OFF_STAT:  next_rdat = 32'(stat);
            `MCT_OFF_ICLR:  next_rdat = 32'h0;
            `MCT_OFF_IEN:   next_rdat = 32'(ien);
            `MCT_OFF_MATCH0:        next_rdat = 32'(match[0]);
            `MCT_OFF_MATCH0 + 6'h4: next_rdat = 32'(match[1]);
            `MCT_OFF_MATCH0 + 6'h8: next_rdat = 32'(match[2]);
            `MCT_OFF_MATCH0 + 6'hc: next_rdat = 32'(match[3]);
            `MCT_OFF_CAP0:          next_rdat = 32'(cap[0]);
            `MCT_OFF_CAP0 + 6'h4:   next_rdat = 32'(cap[1]);
            default: rd_ok = 1'b0;
        endcase
    end

    // Unmapped reads return zero with ack
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            // Zero when idle so instances can share one OR'ed bus
            o_wb_dat <= (i_wb_cyc && i_wb_stb && !o_wb_ack && rd_ok)
                        ? next_rdat : 32'h0;
        end
    end

    // ==========================================================
    // Configuration writes
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= 8'h0;
            plim <= '0;
            mctl <= 8'h0;
            emr_act <= 8'h0;
            cctl <= 4'h0;
            ien <= '0;
            for (int k = 0; k < 4; k++) begin
                match[k] <= '0;
            end
        end else if (wr) begin
            case (i_wb_adr)
                `MCT_OFF_CTRL: begin
                    ctrl <= wdat[7:0];
                end
                `MCT_OFF_PLIM: begin
                    plim <= wdat[W-1:0];
                end
                `MCT_OFF_MCTL: begin
                    mctl <= wdat[7:0];
                end
                `MCT_OFF_EMR: begin
                    emr_act <= wdat[11:4];
                end
                `MCT_OFF_CCTL: begin
                    cctl <= wdat[3:0];
                end
                `MCT_OFF_IEN: begin
                    ien <= wdat[`MCT_IRQ_W-1:0];
                end
                default: begin
                    for (int k = 0; k < 4; k++) begin
                        if (i_wb_adr == `MCT_OFF_MATCH0 + 6'(4 * k)) begin
                            match[k] <= wdat[W-1:0];
                        end
                    end
                end
            endcase
        end else begin
            // Stop on match drops the enable
            for (int k = 0; k < 4; k++) begin
                if (hit[k] && mctl[`MCT_MCTL_W*k + `MCT_MCTL_STOP]) begin
                    ctrl[`MCT_CTRL_EN] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Input edges and capture
    logic [1:0]    cap_rise;
    logic [1:0]    cap_fall;
    logic [1:0]    cap_evt;
    mct_cnt_mode_t cmode;
    logic          csrc;
    logic          cnt_evt;
    logic          clr_evt;
    assign cap_rise = i_cap & ~cap_q;
    assign cap_fall = ~i_cap & cap_q;
    assign cmode = mct_cnt_mode_t'(ctrl[`MCT_CTRL_MODE +: 2]);
    assign csrc = ctrl[`MCT_CTRL_CSEL];

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            cap_evt[c] = (cap_rise[c] && cctl[2*c + `MCT_CCTL_RISE])
                      || (cap_fall[c] && cctl[2*c + `MCT_CCTL_FALL]);
        end
        case (cmode)
            MCT_CNT_RISE: cnt_evt = cap_rise[csrc];
            MCT_CNT_FALL: cnt_evt = cap_fall[csrc];
            MCT_CNT_BOTH: cnt_evt = cap_rise[csrc] || cap_fall[csrc];
            default:      cnt_evt = 1'b0;
        endcase
        clr_evt = ctrl[`MCT_CTRL_CLREN]
               && cap_evt[ctrl[`MCT_CTRL_CLRSEL]];
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cap_q <= 2'b00;
            cap[0] <= '0;
            cap[1] <= '0;
        end else begin
            cap_q <= i_cap;
            for (int c = 0; c < 2; c++) begin
                if (cap_evt[c]) begin
                    cap[c] <= count;
                end
            end
        end
    end

    // ==========================================================
    // Prescaler and counter
    logic       tick;
    logic       mrst;
    always_comb begin
        mrst = 1'b0;
        for (int k = 0; k < 4; k++) begin
            hit[k] = ctrl[`MCT_CTRL_EN] && (count == match[k])
                  && !hit_q[k];
            mrst = mrst || (hit[k] && mctl[`MCT_MCTL_W*k + `MCT_MCTL_RST]);
        end
        tick = (cmode == MCT_CNT_TIMER) ? (pre == plim) : cnt_evt;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre <= '0;
            count <= '0;
            hit_q <= 4'h0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                hit_q[k] <= ctrl[`MCT_CTRL_EN] && (count == match[k]);
            end
            if (wr && i_wb_adr == `MCT_OFF_COUNT) begin
                count <= wdat[W-1:0];
                pre <= '0;
            end else if (ctrl[`MCT_CTRL_CRST] || clr_evt) begin
                count <= '0;
                pre <= '0;
            end else if (mrst) begin
                count <= '0;
                pre <= '0;
            end else if (ctrl[`MCT_CTRL_EN]) begin
                if (cmode == MCT_CNT_TIMER) begin
                    pre <= (pre == plim) ? '0 : pre + 1'b1;
                end
                if (tick) begin
                    count <= count + 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Match outputs
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_match <= 4'h0;
        end else if (wr && i_wb_adr == `MCT_OFF_EMR) begin
            o_match <= wdat[3:0];
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (hit[k]) begin
                    case (mct_ext_act_t'(emr_act[2*k +: 2]))
                        MCT_EXT_LOW:    o_match[k] <= 1'b0;
                        MCT_EXT_HIGH:   o_match[k] <= 1'b1;
                        MCT_EXT_TOGGLE: o_match[k] <= ~o_match[k];
                        default:        o_match[k] <= o_match[k];
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // Interrupt flags, set wins over clear
    logic [`MCT_IRQ_W-1:0] ev;
    logic [`MCT_IRQ_W-1:0] clr;
    assign ev = {cap_evt, hit};
    assign clr = (wr && i_wb_adr == `MCT_OFF_ICLR)
               ? wdat[`MCT_IRQ_W-1:0]
               : '0;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat <= '0;
        end else begin
            stat <= (stat & ~clr) | ev;
        end
    end

    assign o_irq = |(stat & ien);
endmodule

// Two wide and two narrow instances
module mct_timer_set
    import mct_pkg::*;
(
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic [3:0]            i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [`MCT_ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    output logic      [31:0]           o_wb_dat,
    output logic                       o_wb_ack,
    input  wire logic [7:0]            i_cap,
    output logic      [15:0]           o_match,
    output logic      [3:0]            o_irq
);
    logic [31:0] dat [4];
    logic [3:0]  ack;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_t
            mct_timer #(.W(g < 2 ? 32 : 16)) u_t (
                .i_clk_sys (i_clk_sys),
                .i_rst_n   (i_rst_n),
                .i_wb_cyc  (i_wb_cyc[g]),
                .i_wb_stb  (i_wb_stb),
                .i_wb_we   (i_wb_we),
                .i_wb_adr  (i_wb_adr),
                .i_wb_sel  (i_wb_sel),
                .i_wb_dat  (i_wb_dat),
                .o_wb_dat  (dat[g]),
                .o_wb_ack  (ack[g]),
                .i_cap     (i_cap[2*g +: 2]),
                .o_match   (o_match[4*g +: 4]),
                .o_irq     (o_irq[g])
            );
        end
    endgenerate
    assign o_wb_ack = |ack;
    assign o_wb_dat = dat[0] | dat[1] | dat[2] | dat[3];
endmodule
`default_nettype wire

/* File: src/mct_timer_map.svh */
// Register map and field positions of the match/capture timer
// Behaviour
// - Block builds in 32-bit or 16-bit width; two of each are made.
// - Counter and prescaler share the instance width.
// - Timer mode advances counter on prescaled system clock cycles.
// - Counter mode counts external input edges instead.
// - Four match registers compared continuously with the counter.
// - On match the counter may keep running, interrupt only if enabled.
// - Per match option to stop the counter when no bus write falls in the match cycle, optional interrupt.
// - Per match option to reset the counter, optional interrupt.
// - Four match outputs: low, high, toggle or nothing on match.
// - Two capture channels copy the counter on input transitions.
// - Capture event raises interrupt when enabled for that channel.
// - Chosen capture event clears counter and prescaler when configured.
`ifndef MCT_TIMER_MAP_SVH
`define MCT_TIMER_MAP_SVH

`define MCT_ADR_W      6
`define MCT_OFF_CTRL   6'h00
`define MCT_OFF_COUNT  6'h04
`define MCT_OFF_PRE    6'h08
`define MCT_OFF_PLIM   6'h0c
`define MCT_OFF_MCTL   6'h10
`define MCT_OFF_EMR    6'h14
`define MCT_OFF_CCTL   6'h18
`define MCT_OFF_STAT   6'h1c
`define MCT_OFF_ICLR   6'h20
`define MCT_OFF_IEN    6'h24
`define MCT_OFF_MATCH0 6'h28
`define MCT_OFF_CAP0   6'h38

`define MCT_CTRL_EN    0
`define MCT_CTRL_CRST  1
`define MCT_CTRL_MODE  2
`define MCT_CTRL_CSEL  4
`define MCT_CTRL_CLREN 5
`define MCT_CTRL_CLRSEL 6

`define MCT_MCTL_STOP  0
`define MCT_MCTL_RST   1
`define MCT_MCTL_W     2

`define MCT_CCTL_RISE  0
`define MCT_CCTL_FALL  1
`define MCT_CCTL_W     2

`define MCT_IRQ_W      6
`define MCT_IRQ_CAP0   4

`endif

/* File: src/mct_pkg.sv */
// Types shared by the match/capture timer
package mct_pkg;
    typedef enum logic [1:0] {
        MCT_CNT_TIMER,
        MCT_CNT_RISE,
        MCT_CNT_FALL,
        MCT_CNT_BOTH
    } mct_cnt_mode_t;

    typedef enum logic [1:0] {
        MCT_EXT_NONE,
        MCT_EXT_LOW,
        MCT_EXT_HIGH,
        MCT_EXT_TOGGLE
    } mct_ext_act_t;
endpackage

/* File: tb/mct_timer_chk.sv */
// Bound assertion checker for the match/capture timer
`include "mct_timer_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mct_timer_chk (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_wb_cyc,
    input  wire logic                  i_wb_stb,
    input  wire logic                  i_wb_we,
    input  wire logic [`MCT_ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]            i_wb_sel,
    input  wire logic [31:0]           i_wb_dat,
    input  wire logic [31:0]           o_wb_dat,
    input  wire logic                  o_wb_ack,
    input  wire logic [1:0]            i_cap,
    input  wire logic [3:0]            o_match,
    input  wire logic                  o_irq
);
    logic        req;
    logic        wr;
    logic [5:0]  ien;
    logic [31:0] plim;
    logic        en;
    assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wr  = req && i_wb_we && i_wb_sel == 4'hf;
    // Shadows of software-written registers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) ien <= 6'h00;
        else if (wr && i_wb_adr == `MCT_OFF_IEN) ien <= i_wb_dat[5:0];
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) plim <= 32'h0;
        else if (wr && i_wb_adr == `MCT_OFF_PLIM) plim <= i_wb_dat;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) en <= 1'b0;
        else if (wr && i_wb_adr == `MCT_OFF_CTRL) en <= i_wb_dat[0];
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // ==========================================
    // Bus and pin properties
    a_ack_after_req: assert property (req |=> o_wb_ack)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_ack_no_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
        else $error("ack without request");
    a_irq_masked: assert property (ien == 6'h00 |-> !o_irq)
        else $error("interrupt with all sources masked");
    a_ien_readback: assert property (req && !i_wb_we &&
        i_wb_adr == `MCT_OFF_IEN |=> o_wb_dat == {26'h0, ien})
        else $error("enable register read mismatch");
    a_plim_readback: assert property (req && !i_wb_we &&
        i_wb_adr == `MCT_OFF_PLIM |=> o_wb_dat == plim)
        else $error("prescale limit read mismatch");
    a_irq_sticky: assert property (o_irq && !(i_wb_cyc && i_wb_we)
        |=> o_irq)
        else $error("interrupt dropped without software write");
    a_emr_drive: assert property (wr && i_wb_adr == `MCT_OFF_EMR &&
        !en && !$past(en) |=> o_match == $past(i_wb_dat[3:0]))
        else $error("match outputs not set by write");
    c_irq: cover property ($rose(o_irq));
    c_match: cover property ($changed(o_match));
    c_write: cover property (req && i_wb_we ##1 o_wb_ack);
endmodule
bind mct_timer mct_timer_chk mct_timer_chk_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_cap(i_cap), .o_match(o_match), .o_irq(o_irq));
`default_nettype wire

/* File: tb/mct_pin_model.sv */
// Pin-side model: drives capture lines, faces match outputs
`timescale 1ns/1ps
`default_nettype none
module mct_pin_model (
    input  wire logic       i_clk_sys,
    input  wire logic [1:0] i_pulse,
    input  wire logic [3:0] i_match,
    output logic      [1:0] o_cap
);
    initial o_cap = 2'h0;
    // Capture lines follow the commanded pulse one edge later
    always @(posedge i_clk_sys) begin
        o_cap <= i_pulse;
    end
endmodule
`default_nettype wire

/* File: tb/mct_timer_tb.sv */
// Self-checking bench for the match/capture timer
`include "mct_timer_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
 num_errors++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module mct_timer_tb;
    import mct_pkg::*;
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [5:0]  adr = 6'h0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wd = 32'h0, rd, odat, seed = 32'h00016733;
    logic        ack, irq;
    logic [3:0]  mat;
    logic [3:0]  irq4;
    logic [15:0] mat16;
    assign mat = mat16[3:0];
    assign irq = irq4[0];
    logic [1:0]  cap, pulse = 2'h0;
    logic [31:0] p, m, n, w;
    logic        b;
    int          num_errors = 0, n_compared = 0;
    always #2.5 clk = ~clk;
    // Tests wide instance zero through the four-instance top
    mct_timer_set mct_timer_set_inst (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_wb_cyc({3'b000, cyc}), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat(odat),
        .o_wb_ack(ack), .i_cap({6'h00, cap}), .o_match(mat16),
        .o_irq(irq4));
    mct_pin_model mct_pin_model_inst (.i_clk_sys(clk), .i_pulse(pulse),
        .i_match(mat), .o_cap(cap));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic ext_exp(input logic [1:0] a, input logic v);
        case (a)
            2'd1: return 1'b0;
            2'd2: return 1'b1;
            2'd3: return ~v;
            default: return v;
        endcase
    endfunction
    // ==========================================
    // Classic single Wishbone cycle
    task automatic wb(input logic w_, input logic [5:0] a, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1; stb <= 1; we <= w_; adr <= a; wd <= d;
        do begin @(posedge clk); t++; end while (ack !== 1'b1 && t < 50);
        if (t >= 50) begin
            num_errors++;
            end_sim();
        end
        rd = odat;
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        wb(0, `MCT_OFF_STAT, 0); `CHK("stat_rst", 32'h0, rd)
        // ==========================================
        // Stop on match with every output action
        for (int a = 0; a < 4; a++) begin
            p = rnd() % 3 + 2; m = rnd() % 20 + 2; b = rnd() & 1;
            wb(1, `MCT_OFF_PLIM, p); wb(0, `MCT_OFF_PLIM, 0);
            `CHK("plim", p, rd)
            wb(1, `MCT_OFF_MATCH0, m); wb(1, `MCT_OFF_MCTL, 32'h1);
            wb(1, `MCT_OFF_EMR, 32'(a << 4) | 32'(b));
            wb(1, `MCT_OFF_COUNT, 0); wb(1, `MCT_OFF_CTRL, 32'h1);
            rd = 0;
            for (int t = 0; t < 100 && rd[0] !== 1'b1; t++)
                wb(0, `MCT_OFF_STAT, 0);
            `CHK("stat_m0", 1'b1, rd[0])
            wb(0, `MCT_OFF_COUNT, 0); `CHK("cnt_stop", m, rd)
            `CHK("mat0", ext_exp(a[1:0], b), mat[0])
            wb(1, `MCT_OFF_ICLR, 32'h3f);
        end
        // Reset on match, interrupt only when enabled
        wb(1, `MCT_OFF_MCTL, 32'h8); wb(1, `MCT_OFF_MATCH0 + 4, 5);
        wb(1, `MCT_OFF_PLIM, 0); wb(1, `MCT_OFF_COUNT, 0);
        wb(1, `MCT_OFF_CTRL, 32'h1);
        repeat (40) @(posedge clk);
        wb(0, `MCT_OFF_COUNT, 0); `CHK("cnt_lim", 1'b1, rd <= 32'd5)
        wb(0, `MCT_OFF_STAT, 0); `CHK("stat_m1", 1'b1, rd[1])
        `CHK("irq_off", 1'b0, irq)
        wb(1, `MCT_OFF_IEN, 32'h2); `CHK("irq_on", 1'b1, irq)
        wb(0, `MCT_OFF_IEN, 0); `CHK("ien", 32'h2, rd)
        wb(1, `MCT_OFF_CTRL, 0); wb(1, `MCT_OFF_ICLR, 32'h3f);
        `CHK("irq_clr", 1'b0, irq)
        // Counter operation on rising capture input edges
        n = rnd() % 5 + 1;
        wb(1, `MCT_OFF_MCTL, 0); wb(1, `MCT_OFF_COUNT, 0);
        wb(1, `MCT_OFF_CTRL, 32'h5);
        repeat (n) begin
            pulse <= 2'b01; repeat (2) @(posedge clk);
            pulse <= 2'b00; repeat (2) @(posedge clk);
        end
        wb(0, `MCT_OFF_COUNT, 0); `CHK("cnt_ev", n, rd)
        // Pulse width: clear on leading edge, capture on trailing
        w = rnd() % 8 + 4;
        wb(1, `MCT_OFF_CTRL, 0); wb(1, `MCT_OFF_CCTL, 32'h9);
        wb(1, `MCT_OFF_IEN, 32'h30); wb(1, `MCT_OFF_CTRL, 32'h21);
        repeat (rnd() % 30 + 20) @(posedge clk);
        pulse <= 2'b11; repeat (w) @(posedge clk);
        pulse <= 2'b00; repeat (4) @(posedge clk);
        wb(0, `MCT_OFF_CAP0 + 4, 0);
        `CHK("width", 1'b1, rd + 2 >= w && rd <= w + 2)
        wb(0, `MCT_OFF_STAT, 0); `CHK("stat_cap", 2'b11, rd[5:4])
        `CHK("irq_cap", 1'b1, irq)
        end_sim();
    end
endmodule
`default_nettype wire
